// ===== design/pin_sync.sv
// two-flop synchroniser for the pin levels
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // no reset: pin levels carry no control state
    always_ff @(posedge clk) begin
        stage1_ff <= din;
        stage2_ff <= stage1_ff;
    end

    assign dout = stage2_ff;
endmodule
`default_nettype wire

// ===== design/shared_pin_port_a.sv
// port a: data latch, direction, keypad and converter pin takeover, ahb-lite slave
// Operation
// - eight read/write data latch bits form the port data register
// - reset leaves the data latch unchanged
// - direction bit 1 enables the pin driver, 0 makes it input
// - reset clears all eight direction bits
// - enabled keypad input on pins 0-3 overrides port direction and data
// - channel select naming pins 4-7 hands that pin to the converter
// - read returns latch for outputs, synchronised pin level for inputs
// - latch writes always land, input readback unaffected
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`default_nettype none
module shared_pin_port_a (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // port pins
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE,
    // alternate module hand-over
    output logic [3:0] KEYPAD_IRQ_INPUT,
    output logic [3:0] CONVERTER_PIN_SEL
);
    logic [7:0] port_a_latch_ff;
    logic [7:0] port_a_dir_ff;
    logic [3:0] keypad_irq_enable_reg_ff;
    logic [4:0] converter_channel_select_ff;
    logic [7:0] pin_level;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [7:0] rd_addr;
    logic addr_ok;
    logic [7:0] claimed;
    logic [7:0] nxt_oe;
    logic [7:0] nxt_out;
    logic [3:0] nxt_conv;
    logic [31:0] nxt_rdata;

    pin_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk(CORE_CLK),
        .din(PIN_IN),
        .dout(pin_level)
    );

    // converter channel decode, used for claiming and for hand-over
    function automatic logic [3:0] conv_pins(input logic [4:0] ch);
        logic [3:0] sel;
        sel = 4'h0;
        if (ch < 5'(porta_pkg::KEYPAD_PINS)) begin
            sel[ch[1:0]] = 1'b1;
        end
        return sel;
    endfunction

    assign addr_ok = HSEL && HREADY && (HTRANS == porta_pkg::HTRANS_NONSEQ)
                     && (HSIZE == porta_pkg::HSIZE_WORD);
    assign rd_addr = HADDR[7:0];
    assign nxt_conv = conv_pins(converter_channel_select_ff - porta_pkg::CONV_CH_FIRST);
    assign claimed = {nxt_conv, keypad_irq_enable_reg_ff};

    // write data phase capture
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok && HWRITE;
            wr_addr_ff <= rd_addr;
        end
    end

    // data latch has no reset: its content survives reset
    always_ff @(posedge CORE_CLK) begin
        if (wr_pend_ff && wr_addr_ff == porta_pkg::LATCH_OFFSET) begin
            port_a_latch_ff <= HWDATA[7:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            port_a_dir_ff <= porta_pkg::DIR_RESET;
        end else if (wr_pend_ff && wr_addr_ff == porta_pkg::DIR_OFFSET) begin
            port_a_dir_ff <= HWDATA[7:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            keypad_irq_enable_reg_ff <= porta_pkg::KEYPAD_RESET;
        end else if (wr_pend_ff && wr_addr_ff == porta_pkg::KEYPAD_OFFSET) begin
            keypad_irq_enable_reg_ff <= HWDATA[3:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            converter_channel_select_ff <= porta_pkg::CONV_CH_RESET;
        end else if (wr_pend_ff && wr_addr_ff == porta_pkg::CONV_OFFSET) begin
            converter_channel_select_ff <= HWDATA[4:0];
        end
    end

    // read mux, registered so data stand in the data phase
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (rd_addr)
            porta_pkg::LATCH_OFFSET: begin
                nxt_rdata[7:0] = (port_a_dir_ff & port_a_latch_ff)
                               | (~port_a_dir_ff & pin_level);
            end
            porta_pkg::DIR_OFFSET: begin
                nxt_rdata[7:0] = port_a_dir_ff;
            end
            porta_pkg::KEYPAD_OFFSET: begin
                nxt_rdata[3:0] = keypad_irq_enable_reg_ff;
            end
            porta_pkg::CONV_OFFSET: begin
                nxt_rdata[4:0] = converter_channel_select_ff;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            HRDATA <= nxt_rdata;
        end
    end

    // zero wait states, always okay
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // pin drivers: an alternate owner releases the port driver
    always_comb begin
        nxt_oe = port_a_dir_ff & ~claimed;
        nxt_out = port_a_latch_ff & nxt_oe;
    end

    // latch may be unknown after power-up; out is masked by the cleared oe
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            PIN_OE <= porta_pkg::DIR_RESET;
            PIN_OUT <= 8'h00;
            KEYPAD_IRQ_INPUT <= 4'h0;
            CONVERTER_PIN_SEL <= 4'h0;
        end else begin
            PIN_OE <= nxt_oe;
            PIN_OUT <= nxt_out;
            KEYPAD_IRQ_INPUT <= pin_level[3:0] & keypad_irq_enable_reg_ff;
            CONVERTER_PIN_SEL <= nxt_conv;
        end
    end
endmodule
`default_nettype wire

// ===== include/porta_pkg.sv
// package: register map, field positions and reset values of the shared-pin port
`default_nettype none
package porta_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] LATCH_OFFSET = 8'h00;
    localparam logic [7:0] DIR_OFFSET = 8'h04;
    localparam logic [7:0] KEYPAD_OFFSET = 8'h08;
    localparam logic [7:0] CONV_OFFSET = 8'h0c;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [3:0] KEYPAD_RESET = 4'h0;
    localparam logic [4:0] CONV_CH_RESET = 5'h1f;
    localparam logic [4:0] CONV_CH_FIRST = 5'h00;
    localparam int KEYPAD_PINS = 4;
    localparam int CONV_PIN_BASE = 4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire

// ===== tb/pin_model.sv
// pin model: outside drivers on the eight pads, overridden where the port drives
`default_nettype none
module pin_model (
    input wire logic [7:0] oe,
    input wire logic [7:0] drv,
    input wire logic [7:0] ext,
    output logic [7:0] pad
);
    timeunit 1ns;
    timeprecision 100ps;
    assign pad = (oe & drv) | (~oe & ext);
endmodule
`default_nettype wire

// ===== tb/porta_checker.sv
// checker: bus answer, pin drive and takeover relations of port a
`default_nettype none
module porta_checker (
    input wire logic CORE_CLK, RSTN, HREADYOUT, HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic [7:0] PIN_OUT, PIN_OE,
    input wire logic [3:0] KEYPAD_IRQ_INPUT, CONVERTER_PIN_SEL
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    AST_READY: assert property (HREADYOUT && !HRESP) else $error("bus answer wrong");
    AST_UPPER: assert property (HRDATA[31:8] == 24'h0) else $error("upper read bits");
    AST_UNDRV: assert property ((PIN_OUT & ~PIN_OE) == 8'h0) else $error("undriven level");
    AST_CONV: assert property ((PIN_OE[7:4] & CONVERTER_PIN_SEL) == 4'h0)
        else $error("converter pin driven");
    AST_ONEHOT: assert property ($onehot0(CONVERTER_PIN_SEL)) else $error("two pins");
    AST_DIRRST: assert property (disable iff (1'b0) !RSTN |=> PIN_OE == 8'h0)
        else $error("driver on after reset");
    AST_ALTRST: assert property (disable iff (1'b0) !RSTN |=> CONVERTER_PIN_SEL == 4'h0)
        else $error("converter claim after reset");
    AST_KEYRST: assert property (disable iff (1'b0) !RSTN |=> KEYPAD_IRQ_INPUT == 4'h0)
        else $error("keypad claim after reset");
endmodule
`default_nettype wire

// ===== tb/shared_pin_port_a_bench.sv
// bench: direction, latch, readback and takeover scenarios over ahb-lite
`default_nettype none
module shared_pin_port_a_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic CORE_CLK = 1'h0, RSTN = 1'h0, HSEL = 1'h0, HWRITE = 1'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h0;
    logic HREADYOUT, HRESP;
    logic [7:0] PIN_IN, PIN_OUT, PIN_OE, ext = 8'h5a;
    logic [3:0] KEYPAD_IRQ_INPUT, CONVERTER_PIN_SEL;
    int bad_count = 0, cmp_count = 0;
    always #12.5 CORE_CLK = ~CORE_CLK;
    shared_pin_port_a u_dut (.CORE_CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
        .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .PIN_IN, .PIN_OUT,
        .PIN_OE, .KEYPAD_IRQ_INPUT, .CONVERTER_PIN_SEL);
    pin_model u_pins (.oe(PIN_OE), .drv(PIN_OUT), .ext(ext), .pad(PIN_IN));
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task hwait;
        int n;
        n = 0;
        @(posedge CORE_CLK);
        while (HREADYOUT !== 1'b1) begin
            n++;
            if (n > 50) begin
                bad_count++;
                finish_test;
            end
            @(posedge CORE_CLK);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'h1;
        HADDR <= {24'h0, a};
        HTRANS <= porta_pkg::HTRANS_NONSEQ;
        HWRITE <= w;
        HSIZE <= porta_pkg::HSIZE_WORD;
        hwait;
        HTRANS <= 2'h0;
        HWDATA <= d;
        hwait;
        rd = HRDATA;
    endtask
    task settle(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask
    initial begin
        settle(2);
        RSTN <= 1'h1;
        xfer(1'h0, porta_pkg::DIR_OFFSET, 32'h0);
        chk("dir", rd, 32'h0);
        xfer(1'h1, porta_pkg::LATCH_OFFSET, 32'ha5);
        xfer(1'h0, porta_pkg::LATCH_OFFSET, 32'h0);
        chk("pin", rd, 32'h5a);
        xfer(1'h1, porta_pkg::DIR_OFFSET, 32'hff);
        xfer(1'h0, porta_pkg::LATCH_OFFSET, 32'h0);
        chk("latch", rd, 32'ha5);
        settle(1);
        chk("out", PIN_OUT, 32'ha5);
        chk("oe", PIN_OE, 32'hff);
        RSTN <= 1'h0;
        settle(2);
        RSTN <= 1'h1;
        chk("oe rst", PIN_OE, 32'h0);
        xfer(1'h1, porta_pkg::DIR_OFFSET, 32'hff);
        xfer(1'h0, porta_pkg::LATCH_OFFSET, 32'h0);
        chk("kept", rd, 32'ha5);
        xfer(1'h1, porta_pkg::KEYPAD_OFFSET, 32'hf);
        settle(4);
        chk("key oe", PIN_OE, 32'hf0);
        chk("key in", KEYPAD_IRQ_INPUT, 32'ha);
        xfer(1'h1, porta_pkg::KEYPAD_OFFSET, 32'h0);
        for (int c = 0; c < 4; c++) begin
            xfer(1'h1, porta_pkg::CONV_OFFSET, 32'(c));
            settle(1);
            chk("sel", CONVERTER_PIN_SEL, 32'(4'h1 << c));
            chk("sel oe", PIN_OE, 32'(8'hff & ~(8'h10 << c)));
        end
        xfer(1'h0, 8'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        finish_test;
    end
endmodule
bind shared_pin_port_a porta_checker u_chk (.CORE_CLK, .RSTN, .HREADYOUT, .HRESP, .HRDATA,
    .PIN_OUT, .PIN_OE, .KEYPAD_IRQ_INPUT, .CONVERTER_PIN_SEL);
`default_nettype wire
